// ### core/mpm_pkg.sv
// shared constants for the module power manager
package mpm_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int MOD_COUNT = 4;
  localparam int MOD_PAR = 0;
  localparam int MOD_FDC = 1;
  localparam int MOD_SERA = 2;
  localparam int MOD_SERB = 3;
  localparam logic [7:0] FDC_IDLE_STATUS = 8'h80;
  localparam int DLY_SHORT_MS = 10;
  localparam int DLY_LONG_MS = 500;
  localparam int DLY_SHORT_CYC = (CLK_HZ / 1000) * DLY_SHORT_MS;
  localparam int DLY_LONG_CYC = (CLK_HZ / 1000) * DLY_LONG_MS;
  localparam int DLY_W = 23;
  localparam logic MIN_DELAY_SELECT_DEFAULT = 1'b0;
  localparam logic [3:0] RST_MASK = 4'h0;
endpackage

// ### core/mpm_power_manager.sv
// per-module clock gating and floppy auto powerdown control
//
// How it works
// R01 - each of four modules has direct and automatic powerdown modes
// R02 - direct powerdown stops the module clock at once, regardless
// R03 - automatic powerdown gates the clock only while the module is idle; code checks idle on entry only and keeps gating after idle drops
// R04 - chip_clock_off turns the oscillator off, whole chip powered down
// R05 - each module has auto enable, idle flag and direct powerdown bits
// R06 - idle flag is a read-only status output
// R07 - hardware reset or module soft reset ends any powerdown
// R08 - clearing the direct powerdown bit restores the clock
// R09 - module activity ends automatic powerdown
// R10 - software uses module enable only for permanent disabling
// R11 - per-module powerdown leaves the oscillator alone
// R12 - floppy registers kept during idle sleep, unlike direct powerdown
// R13 - floppy auto powerdown armed by command or config enable bit
// R14 - floppy sleeps only when all four entry conditions hold
// R15 - all four motor enables must be inactive
// R16 - floppy idle needs status 80h and interrupt negated
// R17 - head unload timer must have expired
// R18 - powerdown command starts minimum delay timer chosen by select
// R19 - floppy soft reset restarts the minimum delay timer
// R20 - config-armed auto powerdown uses default delay select
// R21 - delay is 10 ms for select 0, 0.5 s for select 1
// R22 - floppy wakes on reset or access to output, status or fifo
// R23 - clock restored glitch-free before the waking access is served
// R24 - direct powerdown overrides automatic powerdown
`timescale 1ns/1ns
module mpm_power_manager
  import mpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // global control
  input wire logic chip_clock_off,
  // per-module configuration bits, index 0 par, 1 fdc, 2 ser a, 3 ser b
  input wire logic [3:0] auto_powerdown_enable,
  input wire logic [3:0] direct_powerdown_bit,
  input wire logic [3:0] module_soft_reset,
  input wire logic [3:0] module_enable_bit,
  // per-module idle and activity from the modules
  input wire logic [3:0] module_idle_in,
  input wire logic [3:0] module_activity,
  // floppy controller status
  input wire logic fdc_auto_pd_enable,
  input wire logic fdc_pd_cmd,
  input wire logic fdc_pd_cmd_min_delay_select,
  input wire logic [3:0] motor_enable_outputs,
  input wire logic [7:0] main_status_reg,
  input wire logic fdc_irq,
  input wire logic head_unload_expired,
  input wire logic fdc_host_access,
  // outputs
  output logic osc_enable,
  output logic [3:0] module_clk_en,
  output logic [3:0] module_idle_flag,
  output logic [3:0] module_in_auto_pd,
  output logic [3:0] module_in_direct_pd,
  output logic fdc_regs_clear,
  output logic fdc_min_delay_select_done
);

  logic [3:0] dpd_r;
  logic [3:0] dpd_nxt;
  logic [3:0] apd_r;
  logic [3:0] apd_nxt;
  logic [3:0] dpd_q_r;
  logic [3:0] idle_sync1_r;
  logic [3:0] idle_sync2_r;
  logic [3:0] act_sync1_r;
  logic [3:0] act_sync2_r;
  logic [3:0] me_sync1_r;
  logic [3:0] me_sync2_r;
  logic [7:0] msr_sync1_r;
  logic [7:0] msr_sync2_r;
  logic irq_sync1_r;
  logic irq_sync2_r;
  logic hut_sync1_r;
  logic hut_sync2_r;
  logic acc_sync1_r;
  logic acc_sync2_r;
  logic fdc_armed_r;
  logic fdc_armed_nxt;
  logic dly_sel_r;
  logic [DLY_W-1:0] dly_cnt_r;
  logic [DLY_W-1:0] dly_cnt_nxt;
  logic dly_done_r;
  logic [3:0] clk_en_r;
  logic osc_r;
  logic regs_clear_r;

  wire logic [3:0] mod_reset = module_soft_reset;
  wire logic [3:0] mod_idle;
  wire logic [3:0] mod_wake;
  wire logic [3:0] mod_sleep_ok;
  wire logic fdc_idle;
  wire logic fdc_entry_ok;
  wire logic fdc_dly_restart;
  wire logic [DLY_W-1:0] dly_target;
  wire logic [3:0] auto_en_eff;
  wire logic fdc_motors_off;
  wire logic dly_reached;
  wire logic [3:0] gate_nxt;

  function automatic logic [DLY_W-1:0] dly_cycles(input logic sel);
    dly_cycles = sel ? DLY_W'(DLY_LONG_CYC) : DLY_W'(DLY_SHORT_CYC); // R21
  endfunction

  // floppy idle: status 80h with no pending interrupt
  assign fdc_idle = (msr_sync2_r == FDC_IDLE_STATUS) && !irq_sync2_r; // R16
  assign fdc_motors_off = (me_sync2_r == 4'h0); // R15
  assign fdc_entry_ok = fdc_motors_off && fdc_idle // R14
                        && hut_sync2_r && dly_done_r; // R17 R18

  assign mod_idle = {idle_sync2_r[MOD_SERB], idle_sync2_r[MOD_SERA],
                     fdc_idle, idle_sync2_r[MOD_PAR]};
  assign auto_en_eff = {auto_powerdown_enable[3:2], fdc_armed_r,
                        auto_powerdown_enable[0]}; // R13
  assign mod_sleep_ok = {mod_idle[3:2], fdc_entry_ok, mod_idle[0]};
  assign mod_wake = act_sync2_r | {2'b00, acc_sync2_r, 1'b0}; // R09 R22

  // direct powerdown follows the config bit; soft reset releases it
  assign dpd_nxt = direct_powerdown_bit & ~mod_reset; // R02 R07 R08

  // auto powerdown entry needs idle; wake or reset leaves it
  assign apd_nxt = auto_en_eff & ~mod_reset & ~mod_wake // R03 R07 R09
                   & (apd_r | mod_sleep_ok);

  // either powerdown gates the clock; direct needs no idle check
  assign gate_nxt = dpd_nxt | apd_nxt; // R02 R24

  // arming via command or config bit
  assign fdc_armed_nxt = fdc_pd_cmd | fdc_auto_pd_enable // R13
                         | (fdc_armed_r & ~fdc_auto_pd_enable & ~fdc_pd_cmd);

  // soft reset or command restarts minimum delay
  assign fdc_dly_restart = fdc_pd_cmd || mod_reset[MOD_FDC]; // R18 R19
  assign dly_target = dly_cycles(dly_sel_r);
  // counter holds at the target so the done flag stays up
  assign dly_reached = (dly_cnt_r >= dly_target);
  assign dly_cnt_nxt = dly_reached ? dly_cnt_r : dly_cnt_r + DLY_W'(1);

  // two-flop synchronisers for inputs from the module clock domains
  always_ff @(posedge clk) begin
    idle_sync1_r <= module_idle_in;
    idle_sync2_r <= idle_sync1_r;
  end

  always_ff @(posedge clk) begin
    act_sync1_r <= module_activity;
    act_sync2_r <= act_sync1_r;
  end

  always_ff @(posedge clk) begin
    me_sync1_r <= motor_enable_outputs;
    me_sync2_r <= me_sync1_r;
  end

  // status bits may tear while changing; entry compares the synchronised value with 80h in a single cycle
  always_ff @(posedge clk) begin
    msr_sync1_r <= main_status_reg;
    msr_sync2_r <= msr_sync1_r;
  end

  always_ff @(posedge clk) begin
    irq_sync1_r <= fdc_irq;
    irq_sync2_r <= irq_sync1_r;
  end

  always_ff @(posedge clk) begin
    hut_sync1_r <= head_unload_expired;
    hut_sync2_r <= hut_sync1_r;
  end

  always_ff @(posedge clk) begin
    acc_sync1_r <= fdc_host_access;
    acc_sync2_r <= acc_sync1_r;
  end

  // direct powerdown state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dpd_r <= RST_MASK; // R07
    end else begin
      dpd_r <= dpd_nxt;
    end
  end

  // automatic powerdown state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apd_r <= RST_MASK; // R07
    end else begin
      apd_r <= apd_nxt;
    end
  end

  // floppy arming is dropped only by hardware reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fdc_armed_r <= 1'b0;
    end else begin
      fdc_armed_r <= fdc_armed_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_sel_r <= MIN_DELAY_SELECT_DEFAULT;
      dly_cnt_r <= '0;
      dly_done_r <= 1'b0;
    end else if (fdc_dly_restart) begin
      // a soft reset restart without a command keeps the current select
      dly_sel_r <= fdc_pd_cmd ? fdc_pd_cmd_min_delay_select : dly_sel_r; // R20
      dly_cnt_r <= '0; // R19
      dly_done_r <= 1'b0;
    end else begin
      if (fdc_auto_pd_enable && !fdc_armed_r) begin
        dly_sel_r <= MIN_DELAY_SELECT_DEFAULT; // R20
      end
      dly_cnt_r <= dly_cnt_nxt;
      dly_done_r <= dly_reached;
    end
  end

  // clock enables change only on a clk edge so gated clocks stay clean;
  // a wake term clears gating on the clk edge after the synchronised access is seen
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_en_r <= 4'hF;
    end else begin
      clk_en_r <= ~gate_nxt; // R02 R23 R24
    end
  end

  // oscillator follows the global bit only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_r <= 1'b1;
    end else begin
      osc_r <= !chip_clock_off; // R04 R11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dpd_q_r <= 4'h0;
    end else begin
      dpd_q_r <= dpd_r;
    end
  end

  // registers lost only on entry into direct powerdown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regs_clear_r <= 1'b0;
    end else begin
      regs_clear_r <= dpd_r[MOD_FDC] && !dpd_q_r[MOD_FDC]; // R12
    end
  end

  // read-only idle status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      module_idle_flag <= 4'h0;
    end else begin
      module_idle_flag <= mod_idle; // R05 R06
    end
  end

  // auto state is reported only when direct powerdown is off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      module_in_auto_pd <= 4'h0;
    end else begin
      module_in_auto_pd <= apd_r & ~dpd_r; // R01 R24
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      module_in_direct_pd <= 4'h0;
    end else begin
      module_in_direct_pd <= dpd_r; // R01
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fdc_min_delay_select_done <= 1'b0;
    end else begin
      fdc_min_delay_select_done <= dly_done_r;
    end
  end

  assign module_clk_en = clk_en_r;
  assign osc_enable = osc_r;
  assign fdc_regs_clear = regs_clear_r;

endmodule

// ### test/mpm_chk_assertions.sv
// port assertions for the module power manager
`timescale 1ns/1ns
module mpm_chk
  import mpm_pkg::*;
(
  // controls
  input wire logic clk, sys_rst, chip_clock_off, fdc_irq, fdc_host_access,
  input wire logic [3:0] direct_powerdown_bit, module_soft_reset,
  input wire logic [3:0] motor_enable_outputs,
  input wire logic [7:0] main_status_reg,
  // status
  input wire logic osc_enable, fdc_regs_clear, fdc_min_delay_select_done,
  input wire logic [3:0] module_clk_en, module_idle_flag, module_in_auto_pd
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  dpd_gate_a: assert property (
    ($stable(direct_powerdown_bit) && $stable(module_soft_reset))[*3]
    |-> (direct_powerdown_bit & ~module_soft_reset & module_clk_en) == 4'h0)
    else $error("clock runs in direct powerdown");
  soft_run_a: assert property ($stable(module_soft_reset)[*3]
    |-> (module_soft_reset & ~module_clk_en) == 4'h0)
    else $error("clock gated under soft reset");
  osc_ctl_a: assert property ($stable(chip_clock_off)[*2]
    |-> osc_enable == !chip_clock_off) else $error("oscillator wrong");
  fdc_idle_a: assert property ($stable({main_status_reg, fdc_irq})[*5]
    |-> module_idle_flag[1] == (main_status_reg == FDC_IDLE_STATUS && !fdc_irq))
    else $error("floppy idle flag wrong");
  entry_dly_a: assert property ($rose(module_in_auto_pd[1])
    |-> fdc_min_delay_select_done) else $error("floppy slept before delay");
  motor_block_a: assert property ((motor_enable_outputs != 4'h0)[*5]
    |-> !$rose(module_in_auto_pd[1])) else $error("slept with motor on");
  host_wake_a: assert property (module_in_auto_pd[1] && fdc_host_access
    |-> ##[1:5] !module_in_auto_pd[1]) else $error("no wake on access");
  clr_pulse_a: assert property (fdc_regs_clear |=> !fdc_regs_clear)
    else $error("register clear not a pulse");
endmodule
bind mpm_power_manager mpm_chk i_chk (.*);

// ### test/tb_mpm_power_manager.sv
// self-checking bench for the module power manager
`timescale 1ns/1ns
module tb_mpm_power_manager;
  import mpm_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, chip_clock_off = 1'b0, fdc_irq = 1'b0;
  logic fdc_auto_pd_enable = 1'b0, fdc_pd_cmd = 1'b0, fdc_pd_cmd_min_delay_select = 1'b0;
  logic head_unload_expired = 1'b0, fdc_host_access = 1'b0;
  logic [3:0] auto_powerdown_enable = 4'h0, direct_powerdown_bit = 4'h0;
  logic [3:0] module_soft_reset = 4'h0, module_enable_bit = 4'hF;
  logic [3:0] module_idle_in = 4'h0, module_activity = 4'h0;
  logic [3:0] motor_enable_outputs = 4'h8;
  logic [7:0] main_status_reg = 8'h00;
  logic osc_enable, fdc_regs_clear, fdc_min_delay_select_done;
  logic [3:0] module_clk_en, module_idle_flag;
  logic [3:0] module_in_auto_pd, module_in_direct_pd;
  int errors = 0;
  int checks_done = 0;
  mpm_power_manager i_dut (.*);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    step(12);
    sys_rst = 1'b0;
    step(1);
    cmp(module_clk_en, 4'hF);
    cmp(module_in_direct_pd | module_in_auto_pd, 4'h0);
    direct_powerdown_bit = 4'h1;
    auto_powerdown_enable = 4'h1;
    module_activity = 4'h1;
    step(4);
    cmp(module_clk_en, 4'hE);
    cmp({osc_enable, module_in_direct_pd[2:0]}, 4'h9);
    direct_powerdown_bit = 4'h0;
    auto_powerdown_enable = 4'h0;
    step(4);
    cmp(module_clk_en, 4'hF);
    module_activity = 4'h0;
    direct_powerdown_bit = 4'h2;
    step(2);
    cmp({3'h0, fdc_regs_clear}, 4'h1);
    step(2);
    cmp(module_clk_en, 4'hD);
    module_soft_reset = 4'hF;
    step(4);
    cmp(module_clk_en, 4'hF);
    cmp({3'h0, fdc_min_delay_select_done}, 4'h0);
    module_soft_reset = 4'h0;
    direct_powerdown_bit = 4'h0;
    chip_clock_off = 1'b1;
    step(3);
    cmp({osc_enable, 3'h0}, 4'h0);
    chip_clock_off = 1'b0;
    auto_powerdown_enable = 4'h4;
    step(6);
    cmp({osc_enable, 3'h0}, 4'h8);
    cmp(module_clk_en, 4'hF);
    module_idle_in = 4'h4;
    step(6);
    cmp(module_in_auto_pd, 4'h4);
    cmp(module_clk_en, 4'hB);
    module_idle_in = 4'h0;
    module_activity = 4'h4;
    step(6);
    cmp(module_clk_en, 4'hF);
    module_activity = 4'h0;
    main_status_reg = FDC_IDLE_STATUS;
    fdc_irq = 1'b1;
    step(6);
    cmp(module_idle_flag, 4'h0);
    fdc_irq = 1'b0;
    fdc_auto_pd_enable = 1'b1;
    fdc_pd_cmd = 1'b1;
    step(1);
    fdc_pd_cmd = 1'b0;
    step(DLY_SHORT_CYC - 20);
    cmp(module_idle_flag, 4'h2);
    cmp({fdc_min_delay_select_done, module_in_auto_pd[1], 2'h0}, 4'h0);
    step(40);
    cmp({fdc_min_delay_select_done, module_in_auto_pd[1], 2'h0}, 4'h8);
    motor_enable_outputs = 4'h0;
    step(8);
    cmp(module_clk_en, 4'hF);
    head_unload_expired = 1'b1;
    step(8);
    cmp(module_clk_en, 4'hD);
    fdc_host_access = 1'b1;
    step(5);
    cmp(module_clk_en, 4'hF);
    fdc_host_access = 1'b0;
    direct_powerdown_bit = 4'hF;
    step(3);
    cmp(module_clk_en, 4'h0);
    sys_rst = 1'b1;
    direct_powerdown_bit = 4'h0;
    step(3);
    cmp(module_clk_en | module_in_direct_pd, 4'hF);
    sys_rst = 1'b0;
    step(2);
    cmp(module_clk_en, 4'hF);
    cmp(module_in_auto_pd | module_in_direct_pd, 4'h0);
    print_verdict();
  end
  initial begin
    step(DLY_SHORT_CYC + 2000);
    errors++;
    print_verdict();
  end
endmodule
